// >>> hw/mfpin_pkg.sv
/*
 * Constants for the multifunction pin output selector: function codes,
 * status bit positions, clock divide figure and reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mfpin_pkg;
   localparam logic [7:0] CODE_LOW = 8'h80;
   localparam logic [7:0] CODE_HIGH = 8'h81;
   localparam logic [7:0] CODE_CLKDIV = 8'h82;
   localparam logic [7:0] CODE_WDOG = 8'h83;
   localparam logic [7:0] CODE_NV_UPLOAD = 8'h84;
   localparam logic [7:0] CODE_NV_DOWNLOAD = 8'h85;
   localparam logic [7:0] CODE_NV_FAULT = 8'h86;
   localparam logic [7:0] CODE_SYS_LOCK = 8'h87;
   localparam logic [7:0] CODE_SYS_STABLE = 8'h88;
   localparam logic [7:0] CODE_OUT_LOCK = 8'h89;
   localparam logic [7:0] CODE_ANA_CAL = 8'h8A;
   localparam logic [7:0] CODE_ANA_REF = 8'h8B;
   localparam logic [7:0] CODE_ALL_LOCK = 8'h8C;
   localparam logic [7:0] CODE_DIG_ANA_LOCK = 8'h8D;
   localparam logic [7:0] CODE_FREE_RUN = 8'h90;
   localparam logic [7:0] CODE_ACTIVE = 8'h91;
   localparam logic [7:0] CODE_HOLDOVER = 8'h92;
   localparam logic [7:0] CODE_SWITCHOVER = 8'h93;
   localparam logic [7:0] CODE_PHASE_LOCK = 8'h94;
   localparam logic [7:0] CODE_FREQ_LOCK = 8'h95;
   localparam logic [7:0] CODE_SLEW_LIM = 8'h96;
   localparam logic [7:0] CODE_FREQ_CLAMP = 8'h97;
   localparam logic [7:0] CODE_HIST_AVAIL = 8'h98;
   localparam logic [7:0] CODE_HIST_UPD = 8'h99;
   localparam logic [7:0] CODE_DIST_SYNC = 8'hD0;
   localparam logic [7:0] CODE_SOFT_CFG = 8'hD1;
   // per-reference groups: high nibble picks kind, low two bits the ref
   localparam logic [3:0] GRP_REF_FAULT = 4'hA;
   localparam logic [3:0] GRP_REF_VALID = 4'hB;
   localparam logic [3:0] GRP_REF_ACTIVE = 4'hC;
   localparam int REF_COUNT = 4;
   localparam int OUTPUT_BIT = 7;
   // nonvolatile store status bits
   localparam int NV_UPLOAD_BIT = 0;
   localparam int NV_DOWNLOAD_BIT = 1;
   localparam int NV_FAULT_BIT = 2;
   // loop status bits
   localparam int PLL_SYS_LOCK_BIT = 0;
   localparam int PLL_SYS_STABLE_BIT = 1;
   localparam int PLL_OUT_LOCK_BIT = 2;
   localparam int PLL_ANA_CAL_BIT = 3;
   localparam int PLL_ANA_REF_BIT = 4;
   localparam int PLL_ALL_LOCK_BIT = 5;
   localparam int PLL_DIG_ANA_BIT = 6;
   localparam int LOOP_FREE_RUN_BIT = 0;
   localparam int LOOP_ACTIVE_BIT = 1;
   localparam int LOOP_HOLDOVER_BIT = 2;
   localparam int LOOP_SWITCH_BIT = 3;
   localparam int LOOP_PHASE_BIT = 4;
   localparam int LOOP_FREQ_BIT = 5;
   localparam int LOOP_SLEW_BIT = 6;
   localparam int LOOP2_HIST_AVAIL_BIT = 4;
   localparam int LOOP2_CLAMP_BIT = 5;
   localparam int EVENT_HIST_UPD_BIT = 4;
   localparam int DIST_SYNC_BIT = 3;
   localparam int DIST_SOFT_CFG_BIT = 4;
   // system clock divide
   localparam int CLK_DIV = 32;
   localparam int CLK_HALF = CLK_DIV / 2;
   localparam int CLK_CNT_W = $clog2(CLK_HALF);
   localparam logic [CLK_CNT_W-1:0] CLK_CNT_RST = 4'h0;
   localparam logic PIN_RST = 1'b0;
   localparam logic [7:0] CODE_RST = 8'h00;
endpackage

// >>> hw/mfpin_status_if.sv
/*
 * Bundle of device status flags carried from the top to the selector.
 * Assumes one driver (the top) and one reader (the selector).
 */
`timescale 1ns/1ps
interface mfpin_status_if;
   logic clk_div;
   logic watchdog;
   logic [2:0] nv_status;
   logic [6:0] pll_status;
   logic [6:0] loop_status;
   logic [5:0] loop2_status;
   logic [4:0] event_status;
   logic [4:0] dist_status;
   logic [3:0] ref_fault;
   logic [3:0] ref_valid;
   logic [1:0] ref_active;
   modport src (
      output clk_div, watchdog, nv_status, pll_status, loop_status,
      output loop2_status, event_status, dist_status,
      output ref_fault, ref_valid, ref_active
   );
   modport sel (
      input clk_div, watchdog, nv_status, pll_status, loop_status,
      input loop2_status, event_status, dist_status,
      input ref_fault, ref_valid, ref_active
   );
endinterface

// >>> hw/mfpin_select.sv
/*
 * Combinational selector: maps a function code to one status level.
 * Assumes the top registers the code and the chosen level; status is live.
 */
`timescale 1ns/1ps
module mfpin_select (
   input wire logic [7:0] i_code,
   mfpin_status_if.sel st,
   output logic o_level
);
   logic [1:0] ref_idx;

   always_comb begin
      ref_idx = i_code[1:0];
      o_level = 1'b0;
      if (i_code[mfpin_pkg::OUTPUT_BIT]) begin
         unique case (i_code)
            mfpin_pkg::CODE_LOW: o_level = 1'b0;
            mfpin_pkg::CODE_HIGH: o_level = 1'b1;
            mfpin_pkg::CODE_CLKDIV: o_level = st.clk_div;
            mfpin_pkg::CODE_WDOG: o_level = st.watchdog;
            mfpin_pkg::CODE_NV_UPLOAD:
               o_level = st.nv_status[mfpin_pkg::NV_UPLOAD_BIT];
            mfpin_pkg::CODE_NV_DOWNLOAD:
               o_level = st.nv_status[mfpin_pkg::NV_DOWNLOAD_BIT];
            mfpin_pkg::CODE_NV_FAULT:
               o_level = st.nv_status[mfpin_pkg::NV_FAULT_BIT];
            mfpin_pkg::CODE_SYS_LOCK:
               o_level = st.pll_status[mfpin_pkg::PLL_SYS_LOCK_BIT];
            mfpin_pkg::CODE_SYS_STABLE:
               o_level = st.pll_status[mfpin_pkg::PLL_SYS_STABLE_BIT];
            mfpin_pkg::CODE_OUT_LOCK:
               o_level = st.pll_status[mfpin_pkg::PLL_OUT_LOCK_BIT];
            mfpin_pkg::CODE_ANA_CAL:
               o_level = st.pll_status[mfpin_pkg::PLL_ANA_CAL_BIT];
            mfpin_pkg::CODE_ANA_REF:
               o_level = st.pll_status[mfpin_pkg::PLL_ANA_REF_BIT];
            mfpin_pkg::CODE_ALL_LOCK:
               o_level = st.pll_status[mfpin_pkg::PLL_ALL_LOCK_BIT];
            mfpin_pkg::CODE_DIG_ANA_LOCK:
               o_level = st.pll_status[mfpin_pkg::PLL_DIG_ANA_BIT];
            mfpin_pkg::CODE_FREE_RUN:
               o_level = st.loop_status[mfpin_pkg::LOOP_FREE_RUN_BIT];
            mfpin_pkg::CODE_ACTIVE:
               o_level = st.loop_status[mfpin_pkg::LOOP_ACTIVE_BIT];
            mfpin_pkg::CODE_HOLDOVER:
               o_level = st.loop_status[mfpin_pkg::LOOP_HOLDOVER_BIT];
            mfpin_pkg::CODE_SWITCHOVER:
               o_level = st.loop_status[mfpin_pkg::LOOP_SWITCH_BIT];
            mfpin_pkg::CODE_PHASE_LOCK:
               o_level = st.loop_status[mfpin_pkg::LOOP_PHASE_BIT];
            mfpin_pkg::CODE_FREQ_LOCK:
               o_level = st.loop_status[mfpin_pkg::LOOP_FREQ_BIT];
            mfpin_pkg::CODE_SLEW_LIM:
               o_level = st.loop_status[mfpin_pkg::LOOP_SLEW_BIT];
            mfpin_pkg::CODE_FREQ_CLAMP:
               o_level = st.loop2_status[mfpin_pkg::LOOP2_CLAMP_BIT];
            mfpin_pkg::CODE_HIST_AVAIL:
               o_level = st.loop2_status[mfpin_pkg::LOOP2_HIST_AVAIL_BIT];
            mfpin_pkg::CODE_HIST_UPD:
               o_level = st.event_status[mfpin_pkg::EVENT_HIST_UPD_BIT];
            mfpin_pkg::CODE_DIST_SYNC:
               o_level = st.dist_status[mfpin_pkg::DIST_SYNC_BIT];
            mfpin_pkg::CODE_SOFT_CFG:
               o_level = st.dist_status[mfpin_pkg::DIST_SOFT_CFG_BIT];
            default: begin
               // only x0..x3 of each reference group are assigned
               if (i_code[3:2] == 2'b00) begin
                  if (i_code[7:4] == mfpin_pkg::GRP_REF_FAULT) begin
                     o_level = st.ref_fault[ref_idx];
                  end else if (i_code[7:4] == mfpin_pkg::GRP_REF_VALID) begin
                     o_level = st.ref_valid[ref_idx];
                  end else if (i_code[7:4] == mfpin_pkg::GRP_REF_ACTIVE) begin
                     o_level = st.ref_valid[ref_idx] &&
                        (st.ref_active == ref_idx);
                  end
               end
            end
         endcase
      end
   end
endmodule

// >>> hw/mfpin_output_select.sv
/*
 * Multifunction pin output selector. Registers the function code,
 * divides the system clock by 32 and drives the chosen level onto the pin.
 * Assumes all status inputs are synchronous to i_clk.
 */
// Behaviour
// - code bit 7 set makes the pin an output; 0x80 low, 0x81 high.
// - 0x82 drives system clock divided by 32; 0x83 the watchdog output.
// - 0x84 drives store upload flag, 0x86 store fault flag.
// - 0x85 drives store download-in-progress flag.
// - 0x87 clock multiplier lock, 0x88 its stable flag.
// - 0x8A drives analog loop calibration-running flag.
// - 0x8B drives analog loop reference-present flag.
// - 0x8C drives AND of digital phase, analog and multiplier locks.
// - 0x8D drives AND of digital phase lock and analog lock.
// - 0x93 drives digital loop reference-switchover flag.
// - 0x96 drives digital loop phase-slew-limited flag.
// - 0x98 drives tuning-word history available flag.
// - 0x99 drives tuning-word history updated flag.
// - 0xD0 drives clock distribution sync pulse.
// - 0xD1 drives soft pin-configuration in progress flag.
`timescale 1ns/1ps
module mfpin_output_select (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [7:0] i_func_code,
   input wire logic i_watchdog,
   input wire logic i_nv_upload,
   input wire logic i_nv_download,
   input wire logic i_nv_fault,
   input wire logic i_sys_lock,
   input wire logic i_sys_stable,
   input wire logic i_out_lock,
   input wire logic i_ana_cal,
   input wire logic i_ana_ref_present,
   input wire logic i_ana_lock,
   input wire logic [6:0] i_loop_status,
   input wire logic [5:0] i_loop2_status,
   input wire logic i_hist_updated,
   input wire logic i_dist_sync,
   input wire logic i_soft_cfg,
   input wire logic [3:0] i_ref_fault,
   input wire logic [3:0] i_ref_valid,
   input wire logic [1:0] i_ref_active,
   output logic o_pin,
   output logic o_pin_oe_n
);
   mfpin_status_if st ();

   logic [mfpin_pkg::CLK_CNT_W-1:0] div_cnt_reg;
   logic clk_div_reg;
   logic [7:0] code_reg;
   logic pin_level;
   logic all_lock;
   logic dig_ana_lock;

   // divide-by-32: toggle every 16 cycles, so the pin square wave is 50%
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_cnt_reg <= mfpin_pkg::CLK_CNT_RST;
         clk_div_reg <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 1'b1;
         if (div_cnt_reg ==
               mfpin_pkg::CLK_CNT_W'(mfpin_pkg::CLK_HALF - 1)) begin
            clk_div_reg <= ~clk_div_reg;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         code_reg <= mfpin_pkg::CODE_RST;
      end else begin
         code_reg <= i_func_code;
      end
   end

   always_comb begin
      dig_ana_lock = i_loop_status[mfpin_pkg::LOOP_PHASE_BIT] &&
         i_ana_lock;
      all_lock = dig_ana_lock && i_sys_lock;
   end

   assign st.clk_div = clk_div_reg;
   assign st.watchdog = i_watchdog;
   assign st.nv_status = {i_nv_fault, i_nv_download, i_nv_upload};
   assign st.pll_status = {dig_ana_lock, all_lock, i_ana_ref_present,
      i_ana_cal, i_out_lock, i_sys_stable, i_sys_lock};
   assign st.loop_status = i_loop_status;
   assign st.loop2_status = i_loop2_status;
   assign st.event_status = {i_hist_updated, 4'h0};
   assign st.dist_status = {i_soft_cfg, i_dist_sync, 3'h0};
   assign st.ref_fault = i_ref_fault;
   assign st.ref_valid = i_ref_valid;
   assign st.ref_active = i_ref_active;

   mfpin_select u_select (
      .i_code(code_reg),
      .st(st),
      .o_level(pin_level)
   );

   // one flop of latency keeps the pin glitch-free on code changes
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pin <= mfpin_pkg::PIN_RST;
         o_pin_oe_n <= 1'b1;
      end else begin
         o_pin <= pin_level;
         o_pin_oe_n <= ~code_reg[mfpin_pkg::OUTPUT_BIT];
      end
   end
endmodule

// >>> dv/board_pin_monitor.sv
/* board logic sampling the multifunction pin; measures level run length.
   assumes the pin is synchronous to i_clk. */
`timescale 1ns/1ps
module board_pin_monitor (
   input wire logic i_clk,
   input wire logic i_pin,
   input wire logic i_pin_oe_n,
   output int o_gap
);
   int run = 0;
   logic last = 1'b0;
   initial o_gap = 0;
   // sampled mid-cycle so the pin has settled; a released pin restarts
   always @(negedge i_clk) begin
      if (i_pin_oe_n) run = 0;
      else if (i_pin !== last) begin
         o_gap = run;
         run = 1;
      end else run = run + 1;
      last = i_pin;
   end
endmodule

// >>> dv/mfpin_pin_properties.sv
/* assertions on the ports of the multifunction pin selector.
   assumes code and status are synchronous to i_clk; bound below. */
`timescale 1ns/1ps
module mfpin_pin_properties (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [7:0] i_func_code,
   input wire logic i_watchdog,
   input wire logic i_nv_download,
   input wire logic i_sys_lock,
   input wire logic i_ana_lock,
   input wire logic [6:0] i_loop_status,
   input wire logic o_pin,
   input wire logic o_pin_oe_n
);
   logic [7:0] code_q;
   logic [1:0] hold_cnt;
   logic held;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // code must have settled through both pipeline stages
   assign held = hold_cnt == 2'h3 && i_func_code == code_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         code_q <= 8'h00;
         hold_cnt <= 2'h0;
      end else begin
         code_q <= i_func_code;
         if (i_func_code != code_q) hold_cnt <= 2'h0;
         else if (hold_cnt != 2'h3) hold_cnt <= hold_cnt + 2'h1;
      end
   end
   out_enable_a: assert property (
      held && i_func_code[7] |=> !o_pin_oe_n)
      else $error("pin not driven for output code");
   in_release_a: assert property (
      held && !i_func_code[7] |=> o_pin_oe_n && !o_pin)
      else $error("pin driven for input code");
   static_lvl_a: assert property (
      held && i_func_code[7:1] == 7'h40 |=>
      o_pin == $past(i_func_code[0]))
      else $error("static level wrong");
   clk_div_a: assert property (
      held && i_func_code == 8'h82 && $changed(o_pin) |=>
      ($stable(o_pin) || i_func_code != 8'h82) [*8])
      else $error("divided clock toggles early");
   watchdog_a: assert property (
      held && i_func_code == 8'h83 |=> o_pin == $past(i_watchdog))
      else $error("watchdog not on pin");
   nv_down_a: assert property (
      held && i_func_code == 8'h85 |=> o_pin == $past(i_nv_download))
      else $error("download flag not on pin");
   all_lock_a: assert property (
      held && i_func_code == 8'h8C |=>
      o_pin == $past(i_loop_status[4] & i_ana_lock & i_sys_lock))
      else $error("all lock wrong");
   dig_ana_a: assert property (
      held && i_func_code == 8'h8D |=>
      o_pin == $past(i_loop_status[4] & i_ana_lock))
      else $error("loop lock pair wrong");
   ref_switch_a: assert property (
      held && i_func_code == 8'h93 |=> o_pin == $past(i_loop_status[3]))
      else $error("switchover flag wrong");
   reserved_a: assert property (
      held && i_func_code == 8'h8E |=> !o_pin)
      else $error("reserved code not low");
endmodule
bind mfpin_output_select mfpin_pin_properties i_props (.i_clk(i_clk),
   .i_arst_n(i_arst_n), .i_func_code(i_func_code), .i_watchdog(i_watchdog),
   .i_nv_download(i_nv_download), .i_sys_lock(i_sys_lock),
   .i_ana_lock(i_ana_lock), .i_loop_status(i_loop_status), .o_pin(o_pin),
   .o_pin_oe_n(o_pin_oe_n));

// >>> dv/tb.sv
/* self-checking bench for the multifunction pin selector.
   assumes a pipeline of two edges from code and one from status. */
`timescale 1ns/1ps
module tb;
   logic i_clk, i_arst_n, o_pin, o_pin_oe_n;
   logic [7:0] code;
   logic [35:0] st;
   logic [7:0] want;
   int error_cnt = 0, compares = 0, cycles = 0, gap;
   mfpin_output_select i_mfpin_output_select (.i_clk(i_clk),
      .i_arst_n(i_arst_n), .i_func_code(code), .i_watchdog(st[0]),
      .i_nv_upload(st[1]), .i_nv_download(st[2]), .i_nv_fault(st[3]),
      .i_sys_lock(st[4]), .i_sys_stable(st[5]), .i_out_lock(st[6]),
      .i_ana_cal(st[7]), .i_ana_ref_present(st[8]), .i_ana_lock(st[9]),
      .i_loop_status(st[16:10]), .i_loop2_status(st[22:17]),
      .i_hist_updated(st[23]), .i_dist_sync(st[24]), .i_soft_cfg(st[25]),
      .i_ref_fault(st[29:26]), .i_ref_valid(st[33:30]),
      .i_ref_active(st[35:34]), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n));
   board_pin_monitor i_board_pin_monitor (.i_clk(i_clk), .i_pin(o_pin),
      .i_pin_oe_n(o_pin_oe_n), .o_gap(gap));
   function automatic logic exp_pin(input logic [7:0] c,
                                    input logic [35:0] s);
      int n;
      n = c[1:0];
      case (c)
         8'h81: return 1'b1;
         8'h8C: return s[14] & s[9] & s[4];
         8'h8D: return s[14] & s[9];
         8'h97: return s[22];
         8'h98: return s[21];
         8'h99: return s[23];
         8'hD0, 8'hD1: return s[24 + c[0]];
         8'hA0, 8'hA1, 8'hA2, 8'hA3: return s[26 + n];
         8'hB0, 8'hB1, 8'hB2, 8'hB3: return s[30 + n];
         8'hC0, 8'hC1, 8'hC2, 8'hC3:
            return s[35:34] == n && s[30 + n];
         default: ;
      endcase
      if (c >= 8'h83 && c <= 8'h8B) begin
         return s[c - 8'h83];
      end
      if (c >= 8'h90 && c <= 8'h96) begin
         return s[10 + c - 8'h90];
      end
      return 1'b0;
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      compares++;
      if (got !== want) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // sweep takes about 2400 cycles; generous ceiling
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 8000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      i_arst_n = 1'b0;
      code = 8'h81;
      st = '0;
      void'($urandom(66));
      repeat (5) @(negedge i_clk);
      check({6'h00, o_pin_oe_n, o_pin}, 8'h02);
      repeat (5) @(negedge i_clk);
      i_arst_n = 1'b1;
      for (int c = 0; c < 256; c++) begin
         code = c[7:0];
         repeat (3) begin
            st[31:0] = $urandom;
            st[35:32] = 4'($urandom);
            repeat (3) @(negedge i_clk);
            want = {6'h00, ~code[7], code[7] & exp_pin(code, st)};
            if (code != 8'h82) begin
               check({6'h00, o_pin_oe_n, o_pin}, want);
            end
         end
      end
      $display("code sweep done");
      code = 8'h82;
      repeat (80) @(negedge i_clk);
      check(8'(gap), 8'h10);
      $display("clock divide done");
      // async reset mid-run releases the pin at once, then 0x81 returns
      code = 8'h81;
      @(negedge i_clk);
      i_arst_n = 1'b0;
      @(negedge i_clk);
      check({6'h00, o_pin_oe_n, o_pin}, 8'h02);
      i_arst_n = 1'b1;
      @(negedge i_clk);
      check({6'h00, o_pin_oe_n, o_pin}, 8'h02);
      @(negedge i_clk);
      check({6'h00, o_pin_oe_n, o_pin}, 8'h01);
      $display("mid-run reset done");
      print_verdict();
   end
endmodule
